// ==== hw/slcr_regs.sv ====
// Two-lane receive and transmit configuration register bank with status.
`timescale 1ns/1ns
// Function
// - Receive loopback off at 00, on at 11, other codes reserved.
// - One receive bit turns sampler offset compensation on or off.
// - Equalizer 0000 fixed maximum gain, 0001 adaptive, 1xxx adaptive lower zero.
// - Clock recovery 000 threshold 1, 001 threshold 17, rest reserved.
// - Loss detect enabled at 100; flag shows amplitude below threshold.
// - Alignment off at 00, comma realignment at 01.
// - Receive polarity bit swaps the receive pair.
// - Rate field scales PLL clock by 2, 1, 1/2, 1/16.
// - Transmit loopback 00 off, 10 driver off, 11 driver on.
// - De-emphasis field selects sixteen reduction steps up to 71.42 percent.
// - Transmit polarity bit swaps the transmit pair.
// - Loss flags read at status bits 3 and 9.
module slcr_regs (
  input wire logic clock, // System clock, 125 MHz.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic [slcr_pkg::ADDR_W-1:0] address, // Byte address.
  input wire logic [31:0] write_data, // Write data.
  input wire logic write_strobe, // One-cycle write request.
  input wire logic read_strobe, // One-cycle read request.
  input wire logic status_select, // Read the lane status register instead.
  output logic [31:0] read_data, // Read data, valid the cycle after.
  input wire logic [1:0] below_threshold, // Per-lane amplitude below threshold.
  output slcr_pkg::slcr_ctl_t lane0_ctl, // Lane 0 decoded controls.
  output slcr_pkg::slcr_ctl_t lane1_ctl // Lane 1 decoded controls.
);
  import slcr_pkg::*;

  slcr_rx_t rx_cfg [2];
  slcr_tx_t tx_cfg [2];
  slcr_rx_t next_rx [2];
  slcr_tx_t next_tx [2];
  logic [31:0] next_read_data;
  logic [1:0] loss_flag;

  function automatic logic [31:0] status_word(input logic [1:0] flags);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[STS_LOSS_LANE0] = flags[0];
    w[STS_LOSS_LANE1] = flags[1];
    return w;
  endfunction

  always_comb begin
    next_rx = rx_cfg;
    next_tx = tx_cfg;
    if (write_strobe && !status_select) begin
      case (address)
        OFF_RX0: next_rx[0] = slcr_rx_t'(write_data & RX_MASK);
        OFF_TX0: next_tx[0] = slcr_tx_t'(write_data & TX_MASK);
        OFF_RX1: next_rx[1] = slcr_rx_t'(write_data & RX_MASK);
        OFF_TX1: next_tx[1] = slcr_tx_t'(write_data & TX_MASK);
        default: ;
      endcase
    end
  end

  always_comb begin
    next_read_data = 32'h0000_0000;
    if (read_strobe) begin
      if (status_select) begin
        next_read_data = (address == OFF_STATUS) ? status_word(loss_flag) : 32'h0000_0000;
      end else begin
        case (address)
          OFF_RX0: next_read_data = 32'(rx_cfg[0]);
          OFF_TX0: next_read_data = 32'(tx_cfg[0]);
          OFF_RX1: next_read_data = 32'(rx_cfg[1]);
          OFF_TX1: next_read_data = 32'(tx_cfg[1]);
          default: next_read_data = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_cfg[0] <= slcr_rx_t'(RX_RESET);
      rx_cfg[1] <= slcr_rx_t'(RX_RESET);
      tx_cfg[0] <= slcr_tx_t'(TX_RESET);
      tx_cfg[1] <= slcr_tx_t'(TX_RESET);
      read_data <= 32'h0000_0000;
    end else begin
      rx_cfg <= next_rx;
      tx_cfg <= next_tx;
      read_data <= next_read_data;
    end
  end

  slcr_lane lane0 (
    .clock(clock),
    .reset_n(reset_n),
    .rx(rx_cfg[0]),
    .tx(tx_cfg[0]),
    .below_threshold(below_threshold[0]),
    .ctl(lane0_ctl),
    .signal_loss_flag(loss_flag[0])
  );

  slcr_lane lane1 (
    .clock(clock),
    .reset_n(reset_n),
    .rx(rx_cfg[1]),
    .tx(tx_cfg[1]),
    .below_threshold(below_threshold[1]),
    .ctl(lane1_ctl),
    .signal_loss_flag(loss_flag[1])
  );

  rx_reserved_a: assert property (@(posedge clock) disable iff (!reset_n)
    (32'(rx_cfg[0]) & ~RX_MASK) == 32'h0000_0000)
    else $error("receive reserved bits not zero");
  write_store_a: assert property (@(posedge clock) disable iff (!reset_n)
    (write_strobe && !status_select && address == OFF_TX1) |=>
    32'(tx_cfg[1]) == ($past(write_data) & TX_MASK))
    else $error("transmit write not stored");
  status_read_a: assert property (@(posedge clock) disable iff (!reset_n)
    (read_strobe && status_select && address == OFF_STATUS) |=>
    read_data[STS_LOSS_LANE1] == $past(loss_flag[1]) &&
    read_data[STS_LOSS_LANE0] == $past(loss_flag[0]))
    else $error("status read wrong");
  enable_path_a: assert property (@(posedge clock) disable iff (!reset_n)
    lane0_ctl.rx_enable == $past(rx_cfg[0].receive_channel_enable))
    else $error("receive enable not passed");
  read_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
    !$past(read_strobe) |-> read_data == 32'h0000_0000)
    else $error("read data without read");

  cov_status_c: cover property (@(posedge clock) disable iff (!reset_n)
    read_strobe && status_select && |loss_flag);
  cov_txloop_c: cover property (@(posedge clock) disable iff (!reset_n)
    lane1_ctl.tx_loopback && !lane1_ctl.tx_driver_on);
  cov_b2b_c: cover property (@(posedge clock) disable iff (!reset_n)
    write_strobe ##1 read_strobe);
endmodule

// ==== hw/slcr_pkg.sv ====
// Package for the lane receive and transmit configuration register bank.
package slcr_pkg;

  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_RX0 = 4'h0;
  localparam logic [3:0] OFF_TX0 = 4'h4;
  localparam logic [3:0] OFF_RX1 = 4'h8;
  localparam logic [3:0] OFF_TX1 = 4'hC;
  localparam logic [3:0] OFF_STATUS = 4'h0;

  localparam logic [31:0] RX_RESET = 32'h0000_0000;
  localparam logic [31:0] TX_RESET = 32'h0000_0100;
  localparam logic [31:0] RX_MASK = 32'h01FF_FFFF;
  localparam logic [31:0] TX_MASK = 32'h003F_FFFF;

  localparam int STS_LOSS_LANE0 = 3;
  localparam int STS_LOSS_LANE1 = 9;

  localparam logic [1:0] RX_LOOP_ON = 2'h3;
  localparam logic [3:0] EQ_FIXED = 4'h0;
  localparam logic [3:0] EQ_ADAPT = 4'h1;
  localparam logic [2:0] CDR_THR1 = 3'h0;
  localparam logic [2:0] CDR_THR17 = 3'h1;
  localparam logic [2:0] LOSS_ON = 3'h4;
  localparam logic [1:0] ALIGN_COMMA = 2'h1;
  localparam logic [1:0] TX_LOOP_OFF_DRV = 2'h2;
  localparam logic [1:0] TX_LOOP_ON_DRV = 2'h3;

  typedef struct packed {
    logic [6:0] reserved;
    logic [1:0] loopback;
    logic offset_comp_enable;
    logic [3:0] equalizer_select;
    logic [2:0] clock_recovery_select;
    logic [2:0] signal_loss_detect_select;
    logic [1:0] align;
    logic [2:0] termination;
    logic polarity_swap;
    logic [1:0] rate;
    logic [2:0] parallel_word_width;
    logic receive_channel_enable;
  } slcr_rx_t;

  typedef struct packed {
    logic [9:0] reserved;
    logic [1:0] loopback;
    logic [1:0] receiver_presence_detect;
    logic electrical_idle_enable;
    logic sync_master_lane;
    logic [3:0] output_deemphasis;
    logic [3:0] swing;
    logic common_mode_adjust;
    logic polarity_swap;
    logic [1:0] rate;
    logic [2:0] parallel_word_width;
    logic transmit_channel_enable;
  } slcr_tx_t;

  // Decoded controls handed to the analog lane.
  typedef struct packed {
    logic rx_enable;
    logic rx_loopback;
    logic offset_comp;
    logic eq_adaptive;
    logic [2:0] eq_zero_sel;
    logic cdr_high_thr;
    logic loss_detect;
    logic comma_align;
    logic rx_invert;
    logic [1:0] rx_rate;
    logic tx_enable;
    logic tx_loopback;
    logic tx_driver_on;
    logic [3:0] deemphasis;
    logic [3:0] swing;
    logic tx_invert;
    logic [1:0] tx_rate;
  } slcr_ctl_t;

endpackage

// ==== hw/slcr_lane.sv ====
// Decoder turning one lane's register pair into analog controls.
`timescale 1ns/1ns
module slcr_lane (
  input wire logic clock, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input slcr_pkg::slcr_rx_t rx, // Receive configuration.
  input slcr_pkg::slcr_tx_t tx, // Transmit configuration.
  input wire logic below_threshold, // Input amplitude below threshold.
  output slcr_pkg::slcr_ctl_t ctl, // Registered decoded controls.
  output logic signal_loss_flag // Loss-of-signal status.
);
  import slcr_pkg::*;

  slcr_ctl_t next_ctl;
  logic next_flag;

  always_comb begin
    next_ctl = '0;
    next_ctl.rx_enable = rx.receive_channel_enable;
    // Reserved codes decode to the safe off state rather than a guess.
    next_ctl.rx_loopback = (rx.loopback == RX_LOOP_ON);
    next_ctl.offset_comp = rx.offset_comp_enable;
    next_ctl.eq_adaptive = (rx.equalizer_select == EQ_ADAPT) || rx.equalizer_select[3];
    next_ctl.eq_zero_sel = rx.equalizer_select[3] ? rx.equalizer_select[2:0] : 3'h0;
    next_ctl.cdr_high_thr = (rx.clock_recovery_select == CDR_THR17);
    next_ctl.loss_detect = (rx.signal_loss_detect_select == LOSS_ON);
    // At code 00 alignment stops at once, with no final realign on the switch.
    next_ctl.comma_align = (rx.align == ALIGN_COMMA);
    next_ctl.rx_invert = rx.polarity_swap;
    next_ctl.rx_rate = rx.rate;
    next_ctl.tx_enable = tx.transmit_channel_enable;
    next_ctl.tx_loopback = (tx.loopback == TX_LOOP_OFF_DRV) ||
                           (tx.loopback == TX_LOOP_ON_DRV);
    next_ctl.tx_driver_on = (tx.loopback != TX_LOOP_OFF_DRV);
    next_ctl.deemphasis = tx.output_deemphasis;
    next_ctl.swing = tx.swing;
    next_ctl.tx_invert = tx.polarity_swap;
    next_ctl.tx_rate = tx.rate;
    next_flag = next_ctl.loss_detect & below_threshold;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctl <= '0;
      signal_loss_flag <= 1'b0;
    end else begin
      ctl <= next_ctl;
      signal_loss_flag <= next_flag;
    end
  end

  loss_flag_a: assert property (@(posedge clock) disable iff (!reset_n)
    signal_loss_flag == $past(rx.signal_loss_detect_select == LOSS_ON && below_threshold))
    else $error("loss flag does not follow detector");
  tx_driver_a: assert property (@(posedge clock) disable iff (!reset_n)
    ($past(tx.loopback) == TX_LOOP_OFF_DRV) |-> (ctl.tx_loopback && !ctl.tx_driver_on))
    else $error("driver not off in loopback code 10");
  align_off_a: assert property (@(posedge clock) disable iff (!reset_n)
    ($past(rx.align) == 2'h0) |-> !ctl.comma_align)
    else $error("alignment active at code 00");
  rx_loop_a: assert property (@(posedge clock) disable iff (!reset_n)
    ctl.rx_loopback == ($past(rx.loopback) == RX_LOOP_ON))
    else $error("receive loopback decode wrong");
endmodule

// ==== verif/tb_slcr_regs.sv ====
// Self-checking testbench for the lane configuration register bank.
`timescale 1ns/1ns
module tb_slcr_regs;
  import slcr_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] address = 4'h0;
  logic [31:0] write_data = 32'h0;
  logic write_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic status_select = 1'b0;
  logic [31:0] read_data;
  logic [1:0] below_threshold = 2'h0;
  slcr_ctl_t lane0_ctl;
  slcr_ctl_t lane1_ctl;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] rd_val;
  logic [3:0] base;
  logic [31:0] ctl_seen;
  logic [31:0] ctl_exp;
  typedef struct packed {logic lane; logic [31:0] rx; logic [31:0] tx;} slcr_row_t;
  slcr_row_t rows [4];

  slcr_regs uut (
    .clock(clock),
    .reset_n(reset_n),
    .address(address),
    .write_data(write_data),
    .write_strobe(write_strobe),
    .read_strobe(read_strobe),
    .status_select(status_select),
    .read_data(read_data),
    .below_threshold(below_threshold),
    .lane0_ctl(lane0_ctl),
    .lane1_ctl(lane1_ctl)
  );

  initial begin
    forever #4 clock = ~clock;
  end

  task automatic stop_test;
    $display("Mismatches %0d, comparisons %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic s);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    status_select <= s;
    @(posedge clock);
    write_strobe <= 1'b0;
    status_select <= 1'b0;
  endtask

  // Read data is only valid in the single cycle after the strobe edge.
  task automatic rd(input logic [3:0] a, input logic s);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    status_select <= s;
    @(posedge clock);
    read_strobe <= 1'b0;
    status_select <= 1'b0;
    #1 rd_val = read_data;
  endtask

  // The whole control word is compared, so that no decoded field can drift unseen.
  function automatic logic [31:0] mask_ctl(slcr_ctl_t c);
    return 32'(c);
  endfunction

  function automatic logic [31:0] exp_ctl(logic [31:0] rx, logic [31:0] tx);
    slcr_ctl_t c;
    c = '0;
    c.rx_enable = rx[0];
    c.rx_loopback = (rx[24:23] == 2'h3);
    c.offset_comp = rx[22];
    c.eq_adaptive = (rx[21:18] == 4'h1) || rx[21];
    c.eq_zero_sel = rx[21] ? rx[20:18] : 3'h0;
    c.cdr_high_thr = (rx[17:15] == 3'h1);
    c.loss_detect = (rx[14:12] == 3'h4);
    c.comma_align = (rx[11:10] == 2'h1);
    c.rx_invert = rx[6];
    c.rx_rate = rx[5:4];
    c.tx_enable = tx[0];
    c.tx_loopback = tx[21];
    c.tx_driver_on = (tx[21:20] != 2'h2);
    c.deemphasis = tx[15:12];
    c.swing = tx[11:8];
    c.tx_invert = tx[6];
    c.tx_rate = tx[5:4];
    return 32'(c);
  endfunction

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors++;
      stop_test;
    end
  end

  initial begin
    rows[0] = '{1'b0, 32'hFFE0_C641, 32'hFFE1_FFF1};
    rows[1] = '{1'b1, 32'h0105_1A30, 32'h0031_51A0};
    rows[2] = '{1'b0, 32'h0000_0200, 32'h0011_0880};
    rows[3] = '{1'b1, 32'h0000_0201, 32'h0001_0F81};
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    rd(OFF_RX0, 1'b0);
    chk(rd_val, 32'h0000_0000);
    rd(OFF_TX0, 1'b0);
    chk(rd_val, 32'h0000_0100);
    foreach (rows[i]) begin
      base = rows[i].lane ? OFF_RX1 : OFF_RX0;
      wr(base, rows[i].rx, 1'b0);
      wr(base + 4'h4, rows[i].tx, 1'b0);
      rd(base, 1'b0);
      chk(rd_val, rows[i].rx & 32'h01FF_FFFF);
      rd(base + 4'h4, 1'b0);
      chk(rd_val, rows[i].tx & 32'h003F_FFFF);
      ctl_seen = mask_ctl(rows[i].lane ? lane1_ctl : lane0_ctl);
      ctl_exp = exp_ctl(rows[i].rx, rows[i].tx);
      chk(ctl_seen, ctl_exp);
    end
    // Writes to a hole in the map or with the status select up must be dropped.
    wr(4'h2, 32'hFFFF_FFFF, 1'b0);
    rd(4'h2, 1'b0);
    chk(rd_val, 32'h0000_0000);
    wr(OFF_TX0, 32'h0000_0F01, 1'b1);
    rd(OFF_TX0, 1'b0);
    chk(rd_val, 32'h0011_0880);
    rd(OFF_TX0, 1'b1);
    chk(rd_val, 32'h0000_0000);
    wr(OFF_RX0, 32'h0000_4200, 1'b0);
    wr(OFF_RX1, 32'h0000_4200, 1'b0);
    below_threshold <= 2'h1;
    repeat (3) @(posedge clock);
    rd(OFF_STATUS, 1'b1);
    chk(rd_val & 32'h0000_0208, 32'h0000_0008);
    @(posedge clock);
    below_threshold <= 2'h2;
    repeat (2) @(posedge clock);
    rd(OFF_STATUS, 1'b1);
    chk(rd_val & 32'h0000_0208, 32'h0000_0200);
    wr(OFF_RX1, 32'h0000_0200, 1'b0);
    below_threshold <= 2'h3;
    repeat (3) @(posedge clock);
    rd(OFF_STATUS, 1'b1);
    chk(rd_val & 32'h0000_0208, 32'h0000_0008);
    // A read right behind a write, with no gap, must already see the new value.
    @(posedge clock);
    address <= OFF_RX1;
    write_data <= 32'h0000_0241;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 rd_val = read_data;
    chk(rd_val, 32'h0000_0241);
    // A second reset in mid-run must restore the register defaults.
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rd(OFF_RX1, 1'b0);
    chk(rd_val, 32'h0000_0000);
    rd(OFF_TX1, 1'b0);
    chk(rd_val, 32'h0000_0100);
    chk(mask_ctl(lane1_ctl), exp_ctl(32'h0, 32'h0000_0100));
    stop_test;
  end
endmodule
